/* video_port_sync_control_bench.sv */
// Self-checking bench for the video port sync control block.
// Assumes one 100 MHz clock shared by Wishbone and the video pins.
`timescale 1ns/1ps
`default_nettype none
module video_port_sync_control_bench;
    import vpsc_pkg::*;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, en = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000, rdat;
    logic [11:0] y = 12'h000, c = 12'h000;
    logic [31:0] wb_dat_out;
    logic wb_ack_out, vb_o, vb_oe, hb_o, hb_oe, ff_o, ff_oe, q_o, q_oe, bus_oe, coding, video_clock_o;
    logic pix_ready, pix_valid, p_vb, p_hb, p_ff, p_q;
    logic [19:0] bus_o, p_bus, prev_bus;
    logic [11:0] pix_y, pix_c;
    logic [1:0] vm_t;
    logic cs_t, hinv_t;
    wire vb_pin = vb_oe ? vb_o : p_vb;
    wire hb_pin = hb_oe ? hb_o : p_hb;
    wire ff_pin = ff_oe ? ff_o : p_ff;
    wire q_pin = q_oe ? q_o : p_q;
    wire [19:0] bus_pin = bus_oe ? bus_o : p_bus;
    int bad_count = 0, check_count = 0, tick = 0, nv, nh, nf, nq;
    bit cap_on = 0, dec_on = 0;
    logic [31:0] rd_q[$];
    logic [23:0] px_q[$], dec_q[$];
    logic [3:0] modes[4] = '{4'h0, 4'h6, 4'h8, 4'h5}; // vmode, csign, hinv
    // Decode control words: 10-bit signed, 8-bit unsigned, 12-bit mux signed
    logic [7:0] dmodes[3] = '{8'h29, 8'h01, 8'h49};
    logic [3:0] sel = 4'hF;
    logic [11:0] ty, tc;
    logic [23:0] last_px = 24'h00_0000;
    always #5 clk = ~clk;
    vpsc_top i_vpsc_top (.sys_clk_in(clk), .reset_in(rst), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
        .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .vblank_in(vb_pin),
        .vblank_out(vb_o), .vblank_oe_out(vb_oe), .hblank_in(hb_pin), .hblank_out(hb_o),
        .hblank_oe_out(hb_oe), .first_field_in(ff_pin), .first_field_out(ff_o),
        .first_field_oe_out(ff_oe), .pixel_clock_qualifier_in(q_pin),
        .pixel_clock_qualifier_out(q_o), .pixel_clock_qualifier_oe_out(q_oe),
        .pixel_bus_in(bus_pin), .pixel_bus_out(bus_o), .pixel_bus_oe_out(bus_oe),
        .coding_mode_out(coding), .video_clock_out(video_clock_o), .pix_y_in(y), .pix_c_in(c),
        .pix_ready_out(pix_ready), .pix_y_out(pix_y), .pix_c_out(pix_c),
        .pix_valid_out(pix_valid));
    vpsc_video_partner i_vpsc_video_partner (.clk_in(clk), .reset_in(rst), .enable_in(en),
        .vblank_out(p_vb), .hblank_out(p_hb), .first_field_out(p_ff), .qual_out(p_q),
        .bus_out(p_bus));
    task give_verdict;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e) begin
            $display("MISMATCH %s expected %h seen %h", n, e, s);
            bad_count++;
        end
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        do @(posedge clk); while (wb_ack_out !== 1'b1);
        rdat = wb_dat_out;
        cyc <= 1'b0; stb <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        wb(1'b0, a, 32'h0000_0000);
    endtask
    task count_pins(input int n);
        nv = 0; nh = 0; nf = 0; nq = 0;
        repeat (n) begin
            @(posedge clk);
            nv += vb_o; nh += hb_o; nf += ff_o; nq += q_o;
        end
    endtask
    task pins(input logic [3:0] oe, input logic [1:0] cm);
        repeat (3) @(posedge clk);
        chk("sync oe", {28'h0, oe}, {28'h0, vb_oe, hb_oe, ff_oe, q_oe});
        chk("coding/bus oe", {30'h0, cm}, {30'h0, coding, bus_oe});
    endtask
    function automatic logic [23:0] exp_px(input logic [19:0] b, input logic [19:0] p);
        logic [11:0] ey, ec;
        case (vm_t)
            VPSC_VM_8BIT: begin ey = {b[19:12], 4'h0}; ec = {b[9:2], 4'h0}; end
            VPSC_VM_12MUX: begin ey = p[19:8]; ec = b[19:8]; end
            default: begin ey = {b[19:10], 2'h0}; ec = {b[9:0], 2'h0}; end
        endcase
        ec[11] = ec[11] ^ cs_t;
        return {ey, ec};
    endfunction
    function automatic logic [23:0] exp_dec(input logic [11:0] ey, input logic [11:0] ec);
        ec[11] = ec[11] ^ cs_t;
        case (vm_t)
            VPSC_VM_8BIT: return {4'h0, ey[11:4], 2'h0, ec[11:4], 2'h0};
            VPSC_VM_12MUX: return {4'h0, ec, 8'h00};
            default: return {4'h0, ey[11:2], ec[11:2]};
        endcase
    endfunction
    always @(posedge clk) begin
        tick++;
        if (tick == 40000) begin
            bad_count++;
            give_verdict;
        end
        if (cap_on && q_pin === 1'b1 && (vb_pin | (hb_pin ^ hinv_t)) === 1'b0) begin
            last_px = exp_px(bus_pin, prev_bus);
            px_q.push_back(last_px);
        end
        prev_bus = bus_pin;
    end
    always @(posedge clk) begin
        if (wb_ack_out === 1'b1 && !we)
            chk("wb_dat_out", rd_q.size() ? rd_q.pop_front() : 32'hDEAD_0000, wb_dat_out);
        if (cap_on && pix_valid === 1'b1)
            chk("capture", px_q.size() ? px_q.pop_front() : 24'hFF_FFFF, {pix_y, pix_c});
        if (dec_on && pix_ready === 1'b1)
            chk("pixel_bus_out", dec_q.size() ? dec_q.pop_front() : 24'hFF_FFFF, bus_o);
    end
    initial begin
        void'($urandom(32'h8330));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(VPSC_CTRL_ADDR, 32'h0000_0000);
        rd(VPSC_HTIM_ADDR, {4'h0, VPSC_HACTIVE_RST, 4'h0, VPSC_HTOTAL_RST});
        rd(VPSC_VTOT_ADDR, {22'h0, VPSC_VTOTAL_RST});
        rd(VPSC_VACT_ADDR, {6'h0, VPSC_VEND_RST, 6'h0, VPSC_VSTART_RST});
        wb(1'b1, 8'h20, 32'hFFFF_FFFF);
        rd(8'h20, 32'h0000_0000);
        // Short line and field so whole fields fit in a small window
        wb(1'b1, VPSC_HTIM_ADDR, 32'h000A_0010);
        wb(1'b1, VPSC_VTOT_ADDR, 32'h0000_0006);
        wb(1'b1, VPSC_VACT_ADDR, 32'h0005_0001);
        rd(VPSC_HTIM_ADDR, 32'h000A_0010);
        wb(1'b1, VPSC_CTRL_ADDR, 32'h0000_0001);
        pins(4'hF, 2'h1);
        // Counters may have run past the new totals and must wrap first
        repeat (20000) @(posedge clk);
        count_pins(192);
        chk("vblank high", 32'd64, nv);
        chk("hblank high", 32'd72, nh);
        chk("field high", 32'd96, nf);
        chk("qualifier high", 32'd40, nq);
        wb(1'b1, VPSC_CTRL_ADDR, 32'h0000_0005);
        repeat (4) @(posedge clk);
        count_pins(192);
        chk("hblank inverted", 32'd120, nh);
        chk("qualifier inverted", 32'd40, nq);
        $display("test master sync done");
        wb(1'b1, VPSC_CTRL_ADDR, 32'h0000_0011);
        repeat (4) @(posedge clk);
        nv = 0;
        repeat (20) begin
            nf = video_clock_o;
            @(posedge clk);
            nv += (nf != video_clock_o);
        end
        chk("clock out toggles", 32'd20, nv);
        wb(1'b1, VPSC_CTRL_ADDR, 32'h0000_0029);
        @(posedge clk);
        #1 chk("clock out high", 32'h1, {31'h0, video_clock_o});
        #5 chk("clock out low", 32'h0, {31'h0, video_clock_o});
        $display("test clock out done");
        // New samples go out on the edge a pair is taken, so the next pair sees them
        foreach (dmodes[i]) begin
            {vm_t, cs_t} = {dmodes[i][6:5], dmodes[i][3]};
            wb(1'b1, VPSC_CTRL_ADDR, {24'h00_0000, dmodes[i]});
            do @(posedge clk); while (pix_ready !== 1'b1);
            dec_on <= 1'b1;
            repeat (9) begin
                ty = 12'($urandom);
                tc = 12'($urandom);
                y <= ty;
                c <= tc;
                dec_q.push_back(exp_dec(ty, tc));
                do @(posedge clk); while (pix_ready !== 1'b1);
            end
            dec_on <= 1'b0;
        end
        @(posedge clk);
        chk("decodes left", 32'h0, dec_q.size());
        $display("test decode done");
        foreach (modes[i]) begin
            {vm_t, cs_t, hinv_t} = modes[i];
            wb(1'b1, VPSC_CTRL_ADDR, {25'h0, vm_t, 1'b0, cs_t, hinv_t, 2'h2});
            pins(4'h0, 2'h2);
            en <= 1'b1;
            cap_on = 1;
            repeat (300) @(posedge clk);
            en <= 1'b0;
            repeat (6) @(posedge clk);
            cap_on = 0;
            chk("captures left", 32'h0, px_q.size());
            px_q.delete();
            rd(VPSC_CAPT_ADDR, {4'h0, last_px[11:0], 4'h0, last_px[23:12]});
        end
        $display("test slave encode done");
        // Partial byte selects must leave the unselected field alone
        sel <= 4'h1;
        wb(1'b1, VPSC_HTIM_ADDR, 32'h0FFF_0FFF);
        sel <= 4'hC;
        wb(1'b1, VPSC_HTIM_ADDR, 32'h0ABC_0FFF);
        sel <= 4'hF;
        rd(VPSC_HTIM_ADDR, 32'h0ABC_0010);
        $display("test byte select done");
        // Let the last read's compare run before the verdict
        repeat (2) @(posedge clk);
        give_verdict;
    end
endmodule // video_port_sync_control_bench
`default_nettype wire

/* vpsc_pkg.sv */
// Package for the video port sync control block: register map, field layout, reset values.
// Assumes one 100 MHz system clock that also paces the video port.
package vpsc_pkg;
    localparam int VPSC_AW = 8;
    localparam logic [7:0] VPSC_CTRL_ADDR = 8'h00;
    localparam logic [7:0] VPSC_HTIM_ADDR = 8'h04;
    localparam logic [7:0] VPSC_VTOT_ADDR = 8'h08;
    localparam logic [7:0] VPSC_VACT_ADDR = 8'h0C;
    localparam logic [7:0] VPSC_STAT_ADDR = 8'h10;
    localparam logic [7:0] VPSC_CAPT_ADDR = 8'h14;
    // Control register, upper field and status register bit positions
    localparam int VPSC_CTRL_MASTER = 0;
    localparam int VPSC_CTRL_ENCODE = 1;
    localparam int VPSC_CTRL_HINV = 2;
    localparam int VPSC_CTRL_CSIGN = 3;
    localparam int VPSC_CTRL_DIV2 = 4;
    localparam int VPSC_CTRL_VMODE_LO = 5;
    localparam int VPSC_HI_FIELD_LO = 16;
    localparam int VPSC_STAT_VBLANK = 0;
    localparam int VPSC_STAT_HBLANK = 1;
    localparam int VPSC_STAT_FIELD = 2;
    localparam int VPSC_STAT_PHASE = 3;
    // Video interface modes: lane layout of the pixel bus
    localparam logic [1:0] VPSC_VM_8BIT = 2'h0;
    localparam logic [1:0] VPSC_VM_10BIT = 2'h1;
    localparam logic [1:0] VPSC_VM_12MUX = 2'h2;
    // Reset values of the timing registers, then sample and bus widths
    localparam logic [11:0] VPSC_HTOTAL_RST = 12'h06B4;
    localparam logic [11:0] VPSC_HACTIVE_RST = 12'h05A0;
    localparam logic [9:0] VPSC_VTOTAL_RST = 10'h107;
    localparam logic [9:0] VPSC_VSTART_RST = 10'h014;
    localparam logic [9:0] VPSC_VEND_RST = 10'h106;
    localparam int VPSC_SW = 12;
    localparam int VPSC_BW = 20;
endpackage

/* vpsc_top.sv */
// Video port sync control: blanking, field, qualifier, coding mode, pixel bus and clock out.
// Assumes pins are synchronous to sys_clk_in; registers reached over classic Wishbone.
`timescale 1ns/1ps
`default_nettype none
module vpsc_top
    import vpsc_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [VPSC_AW-1:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    input wire logic vblank_in,
    output logic vblank_out,
    output logic vblank_oe_out,
    input wire logic hblank_in,
    output logic hblank_out,
    output logic hblank_oe_out,
    input wire logic first_field_in,
    output logic first_field_out,
    output logic first_field_oe_out,
    input wire logic pixel_clock_qualifier_in,
    output logic pixel_clock_qualifier_out,
    output logic pixel_clock_qualifier_oe_out,
    input wire logic [VPSC_BW-1:0] pixel_bus_in,
    output logic [VPSC_BW-1:0] pixel_bus_out,
    output logic pixel_bus_oe_out,
    output logic coding_mode_out,
    output logic video_clock_out,
    input wire logic [VPSC_SW-1:0] pix_y_in,
    input wire logic [VPSC_SW-1:0] pix_c_in,
    output logic pix_ready_out,
    output logic [VPSC_SW-1:0] pix_y_out,
    output logic [VPSC_SW-1:0] pix_c_out,
    output logic pix_valid_out
);

    typedef struct packed {
        logic master;
        logic encode;
        logic hinv;
        logic csign;
        logic div2;
        logic [1:0] vmode;
        logic [11:0] htotal;
        logic [11:0] hactive;
        logic [9:0] vtotal;
        logic [9:0] vstart;
        logic [9:0] vend;
        logic [11:0] h_cnt;
        logic [9:0] v_cnt;
        logic first_field;
        logic phase;
        logic vblank_o;
        logic hblank_o;
        logic field_o;
        logic qual_o;
        logic [VPSC_BW-1:0] bus_o;
        logic clk_o;
        logic s_vblank;
        logic s_hblank;
        logic s_field;
        logic s_qual;
        logic [VPSC_BW-1:0] s_bus;
        logic [VPSC_SW-1:0] y_hold;
        logic [VPSC_SW-1:0] cap_y;
        logic [VPSC_SW-1:0] cap_c;
        logic cap_valid;
        logic take;
        logic ack;
        logic [31:0] rdat;
    } vpsc_state_s;

    vpsc_state_s st_r;
    vpsc_state_s st_nxt;

    // Offset binary inside, two's complement on the pins when signed: flip the MSB
    function automatic logic [VPSC_SW-1:0] vpsc_chroma(input logic sgn,
                                                       input logic [VPSC_SW-1:0] c);
        vpsc_chroma = sgn ? {~c[VPSC_SW-1], c[VPSC_SW-2:0]} : c;
    endfunction

    // Lane layout for the non-multiplexed modes; 12-bit mode is handled by phase
    function automatic logic [VPSC_BW-1:0] vpsc_pack(input logic [1:0] m,
                                                     input logic [VPSC_SW-1:0] y,
                                                     input logic [VPSC_SW-1:0] c);
        if (m == VPSC_VM_8BIT) begin
            vpsc_pack = {y[11:4], 2'b00, c[11:4], 2'b00};
        end else begin
            vpsc_pack = {y[11:2], c[11:2]};
        end
    endfunction

    logic wb_req;
    logic line_end;
    logic line_blank;
    logic pix_blank;
    logic active;
    logic s_active;
    logic [11:0] h_next;
    logic [9:0] v_next;

    assign wb_req = wb_cyc_in && wb_stb_in && !st_r.ack;
    assign line_end = (st_r.h_cnt == st_r.htotal - 12'h001);
    assign line_blank = (st_r.v_cnt < st_r.vstart) || (st_r.v_cnt >= st_r.vend);
    assign pix_blank = (st_r.h_cnt >= st_r.hactive);
    assign active = !line_blank && !pix_blank;
    // Sampled blanking is normalised to active high before use
    assign s_active = !st_r.s_vblank && !(st_r.s_hblank ^ st_r.hinv);
    assign h_next = line_end ? 12'h000 : st_r.h_cnt + 12'h001;
    assign v_next = (st_r.v_cnt == st_r.vtotal - 10'h001) ? 10'h000 : st_r.v_cnt + 10'h001;

    always_comb begin
        st_nxt = st_r;
        st_nxt.take = 1'b0;
        st_nxt.cap_valid = 1'b0;
        // Register bus: one wait state, unmapped offsets read zero
        st_nxt.ack = wb_req;
        if (wb_req && wb_we_in) begin
            unique case (wb_adr_in)
                VPSC_CTRL_ADDR: begin
                    if (wb_sel_in[0]) begin
                        st_nxt.master = wb_dat_in[VPSC_CTRL_MASTER];
                        st_nxt.encode = wb_dat_in[VPSC_CTRL_ENCODE];
                        st_nxt.hinv = wb_dat_in[VPSC_CTRL_HINV];
                        st_nxt.csign = wb_dat_in[VPSC_CTRL_CSIGN];
                        st_nxt.div2 = wb_dat_in[VPSC_CTRL_DIV2];
                        st_nxt.vmode = wb_dat_in[VPSC_CTRL_VMODE_LO +: 2];
                    end
                end
                VPSC_HTIM_ADDR: begin
                    if (wb_sel_in[1:0] == 2'b11) begin
                        st_nxt.htotal = wb_dat_in[11:0];
                    end
                    if (wb_sel_in[3:2] == 2'b11) begin
                        st_nxt.hactive = wb_dat_in[VPSC_HI_FIELD_LO +: 12];
                    end
                end
                VPSC_VTOT_ADDR: begin
                    if (wb_sel_in[1:0] == 2'b11) begin
                        st_nxt.vtotal = wb_dat_in[9:0];
                    end
                end
                VPSC_VACT_ADDR: begin
                    if (wb_sel_in[1:0] == 2'b11) begin
                        st_nxt.vstart = wb_dat_in[9:0];
                    end
                    if (wb_sel_in[3:2] == 2'b11) begin
                        st_nxt.vend = wb_dat_in[VPSC_HI_FIELD_LO +: 10];
                    end
                end
                default: begin
                end
            endcase
        end
        st_nxt.rdat = 32'h0000_0000;
        if (wb_req && !wb_we_in) begin
            unique case (wb_adr_in)
                VPSC_CTRL_ADDR: begin
                    st_nxt.rdat[VPSC_CTRL_MASTER] = st_r.master;
                    st_nxt.rdat[VPSC_CTRL_ENCODE] = st_r.encode;
                    st_nxt.rdat[VPSC_CTRL_HINV] = st_r.hinv;
                    st_nxt.rdat[VPSC_CTRL_CSIGN] = st_r.csign;
                    st_nxt.rdat[VPSC_CTRL_DIV2] = st_r.div2;
                    st_nxt.rdat[VPSC_CTRL_VMODE_LO +: 2] = st_r.vmode;
                end
                VPSC_HTIM_ADDR: begin
                    st_nxt.rdat = {4'h0, st_r.hactive, 4'h0, st_r.htotal};
                end
                VPSC_VTOT_ADDR: begin
                    st_nxt.rdat = {22'h00_0000, st_r.vtotal};
                end
                VPSC_VACT_ADDR: begin
                    st_nxt.rdat = {6'h00, st_r.vend, 6'h00, st_r.vstart};
                end
                VPSC_STAT_ADDR: begin
                    st_nxt.rdat[VPSC_STAT_VBLANK] = st_r.s_vblank;
                    st_nxt.rdat[VPSC_STAT_HBLANK] = st_r.s_hblank ^ st_r.hinv;
                    st_nxt.rdat[VPSC_STAT_FIELD] = st_r.s_field;
                    st_nxt.rdat[VPSC_STAT_PHASE] = st_r.phase;
                    st_nxt.rdat[VPSC_HI_FIELD_LO +: 10] = st_r.v_cnt;
                end
                VPSC_CAPT_ADDR: begin
                    st_nxt.rdat = {4'h0, st_r.cap_c, 4'h0, st_r.cap_y};
                end
                default: begin
                end
            endcase
        end

        // Raster timing; runs in both modes, only drives pins as master
        st_nxt.phase = !st_r.phase;
        st_nxt.h_cnt = h_next;
        if (line_end) begin
            st_nxt.v_cnt = v_next;
            if (v_next == 10'h000) begin
                st_nxt.first_field = !st_r.first_field;
            end
        end
        st_nxt.vblank_o = line_blank;
        st_nxt.hblank_o = pix_blank ^ st_r.hinv;
        st_nxt.field_o = st_r.first_field;
        st_nxt.qual_o = st_r.phase && active;

        // Clock out: free-running toggle so the halved clock keeps a 50% duty
        st_nxt.clk_o = !st_r.clk_o;

        // Decode: launch samples on the bus, user sees take when y/c are consumed
        st_nxt.bus_o = '0;
        if (active && !st_r.encode) begin
            if (st_r.vmode == VPSC_VM_12MUX) begin
                st_nxt.bus_o[VPSC_BW-1 -: VPSC_SW] = st_r.phase ?
                    vpsc_chroma(st_r.csign, pix_c_in) : pix_y_in;
            end else begin
                st_nxt.bus_o = vpsc_pack(st_r.vmode, pix_y_in,
                                         vpsc_chroma(st_r.csign, pix_c_in));
            end
            st_nxt.take = st_r.phase;
        end

        // Sample pins; as master the own sync outputs stand in for the sync inputs, the bus is always taken from its pins
        st_nxt.s_vblank = st_r.master ? st_r.vblank_o : vblank_in;
        st_nxt.s_hblank = st_r.master ? st_r.hblank_o : hblank_in;
        st_nxt.s_field = st_r.master ? st_r.field_o : first_field_in;
        st_nxt.s_qual = st_r.master ? st_r.qual_o : pixel_clock_qualifier_in;
        st_nxt.s_bus = pixel_bus_in;

        // Encode: capture only in qualified phases of active video
        if (st_r.encode && !st_r.s_qual) begin
            st_nxt.y_hold = st_r.s_bus[VPSC_BW-1 -: VPSC_SW];
        end
        if (st_r.encode && st_r.s_qual && s_active) begin
            st_nxt.cap_valid = 1'b1;
            unique case (st_r.vmode)
                VPSC_VM_8BIT: begin
                    st_nxt.cap_y = {st_r.s_bus[19:12], 4'h0};
                    st_nxt.cap_c = vpsc_chroma(st_r.csign, {st_r.s_bus[9:2], 4'h0});
                end
                VPSC_VM_10BIT: begin
                    st_nxt.cap_y = {st_r.s_bus[19:10], 2'b00};
                    st_nxt.cap_c = vpsc_chroma(st_r.csign, {st_r.s_bus[9:0], 2'b00});
                end
                VPSC_VM_12MUX: begin
                    st_nxt.cap_y = st_r.y_hold;
                    st_nxt.cap_c = vpsc_chroma(st_r.csign, st_r.s_bus[VPSC_BW-1 -: VPSC_SW]);
                end
                default: begin
                    st_nxt.cap_valid = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            st_r <= '0;
            st_r.htotal <= VPSC_HTOTAL_RST;
            st_r.hactive <= VPSC_HACTIVE_RST;
            st_r.vtotal <= VPSC_VTOTAL_RST;
            st_r.vstart <= VPSC_VSTART_RST;
            st_r.vend <= VPSC_VEND_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign wb_dat_out = st_r.rdat;
    assign wb_ack_out = st_r.ack;
    assign vblank_out = st_r.vblank_o;
    assign hblank_out = st_r.hblank_o;
    assign first_field_out = st_r.field_o;
    assign vblank_oe_out = st_r.master;
    assign hblank_oe_out = st_r.master;
    assign first_field_oe_out = st_r.master;
    assign pixel_clock_qualifier_out = st_r.qual_o;
    assign pixel_clock_qualifier_oe_out = st_r.master;
    assign pixel_bus_out = st_r.bus_o;
    assign pixel_bus_oe_out = !st_r.encode;
    assign coding_mode_out = st_r.encode;
    // Undivided mode has to pass the clock itself; no flop can reproduce it
    assign video_clock_out = st_r.div2 ? st_r.clk_o : sys_clk_in;
    assign pix_ready_out = st_r.take;
    assign pix_y_out = st_r.cap_y;
    assign pix_c_out = st_r.cap_c;
    assign pix_valid_out = st_r.cap_valid;

    default clocking vpsc_cb @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);

    // Mode 3 captures nothing by choice, so it is kept out of the trigger
    sequence vpsc_qual_seen;
        st_r.encode && st_r.s_qual && s_active && st_r.vmode <= VPSC_VM_12MUX;
    endsequence
    sequence vpsc_capture_done;
        pix_valid_out;
    endsequence

    sync_direction_a: assert property (vblank_oe_out == hblank_oe_out &&
        first_field_oe_out == hblank_oe_out && vblank_oe_out == st_r.master)
        else $error("sync pin direction differs from master bit");
    vblank_level_a: assert property (st_r.master |=> vblank_out ==
        ($past(st_r.v_cnt) < $past(st_r.vstart) || $past(st_r.v_cnt) >= $past(st_r.vend)))
        else $error("vertical blank level wrong for line");
    hblank_polarity_a: assert property (st_r.master |=> hblank_out ==
        (($past(st_r.h_cnt) >= $past(st_r.hactive)) ^ $past(st_r.hinv)))
        else $error("horizontal blank level or polarity wrong");
    field_level_a: assert property (st_r.master |=> first_field_out == $past(st_r.first_field))
        else $error("field output does not follow field state");
    bus_direction_a: assert property (pixel_bus_oe_out != coding_mode_out)
        else $error("pixel bus driven while encoding");
    qual_alternate_a: assert property (pixel_clock_qualifier_out |=>
        !pixel_clock_qualifier_out)
        else $error("qualifier high in two adjacent phases");
    clock_half_a: assert property (st_r.div2 && $past(st_r.div2) |->
        st_r.clk_o != $past(st_r.clk_o))
        else $error("halved clock did not toggle");
    capture_cause_a: assert property (vpsc_capture_done |-> $past(st_r.s_qual) &&
        $past(st_r.encode))
        else $error("pixel captured without qualifier");
    capture_follow_a: assert property (vpsc_qual_seen |=> vpsc_capture_done)
        else $error("qualified pixel not captured");
    chroma_sign_a: assert property (pix_valid_out && $past(st_r.vmode) == VPSC_VM_10BIT |->
        pix_c_out[VPSC_SW-1] == ($past(st_r.s_bus[9]) ^ $past(st_r.csign)))
        else $error("chroma sign handling wrong");
    wb_ack_once_a: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack held for more than one cycle");

endmodule // vpsc_top
`default_nettype wire

/* vpsc_video_partner.sv */
// External video source facing the block's pins in slave encode mode.
// Assumes the bench resolves each pin from the device's output enables.
`timescale 1ns/1ps
`default_nettype none
module vpsc_video_partner (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic enable_in,
    output logic vblank_out,
    output logic hblank_out,
    output logic first_field_out,
    output logic qual_out,
    output logic [19:0] bus_out
);
    logic phase_r;
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            phase_r <= 1'b0;
            qual_out <= 1'b0;
            vblank_out <= 1'b1;
            hblank_out <= 1'b1;
            first_field_out <= 1'b0;
            bus_out <= 20'h0_0000;
        end else begin
            phase_r <= ~phase_r;
            qual_out <= enable_in & phase_r;
            // Occasional blanking proves that blanked samples are dropped
            vblank_out <= ~enable_in | ($urandom % 16 == 0);
            hblank_out <= ~enable_in | ($urandom % 8 == 0);
            first_field_out <= 1'($urandom);
            // Bus keeps changing even when idle, so stale values never look valid
            bus_out <= 20'($urandom);
        end
    end
endmodule // vpsc_video_partner
`default_nettype wire
